// ### logic/ram_pkg.sv
// Purpose: shared constants, types and helpers of the large dual-port RAM block
// Assumes: one system clock; port clocks arrive as sampled level inputs
// Notes:   8192 words of 72 bits, eight 9-bit byte lanes (parity included)
package ram_pkg;
  // ==========================================================================
  // geometry
  localparam int DW         = 72;
  localparam int AW         = 16;
  localparam int BEW        = 8;
  localparam int LANE       = DW / BEW;
  localparam int TOTAL_BITS = 589824;
  localparam int DEPTH      = TOTAL_BITS / DW;
  localparam int IDXW       = $clog2(DEPTH);
  localparam int CW         = IDXW + 1;

  // ==========================================================================
  // register map, byte addresses on the apb bus
  localparam int             PAW      = 8;
  localparam logic [PAW-1:0] OFS_CTRL = 8'h00;
  localparam logic [PAW-1:0] OFS_STAT = 8'h04;
  localparam logic [PAW-1:0] OFS_ERR  = 8'h08;

  // control field positions and reset value
  localparam int         CF_MODE   = 0;
  localparam int         CF_OREG_A = 2;
  localparam int         CF_ISEL_A = 3;
  localparam int         CF_OSEL_A = 4;
  localparam int         CF_OREG_B = 5;
  localparam int         CF_ISEL_B = 6;
  localparam int         CF_OSEL_B = 7;
  localparam logic [7:0] CTRL_RST  = 8'h00;

  // sticky error field positions and reset value
  localparam int         EF_OVF  = 0;
  localparam int         EF_UDF  = 1;
  localparam int         EF_REF  = 2;
  localparam logic [2:0] ERR_RST = 3'h0;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    MODE_TDP  = 2'b00,
    MODE_SDP  = 2'b01,
    MODE_SP   = 2'b11,
    MODE_FIFO = 2'b10
  } mode_t;

  typedef struct packed {
    logic           wr;
    logic [AW-1:0]  addr;
    logic [BEW-1:0] be;
    logic [DW-1:0]  data;
  } req_t;

  // replace only the lanes whose enable is set
  function automatic logic [DW-1:0] merge_lanes(input logic [DW-1:0]  old_w,
                                                input logic [DW-1:0]  new_w,
                                                input logic [BEW-1:0] be);
    logic [DW-1:0] res;
    res = old_w;
    for (int i = 0; i < BEW; i++) begin
      if (be[i]) begin
        res[i*LANE +: LANE] = new_w[i*LANE +: LANE];
      end
    end
    return res;
  endfunction
endpackage

// ### logic/port_regs.sv
// Purpose: input register group of one ram port
// Assumes: tick is a one-cycle pulse marking the selected port clock edge
// Notes:   clear acts at once; the array sees it at the next edge
`timescale 1ns/1ps
module port_regs (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  tick,
  input  wire logic                  clocken,
  input  wire logic                  renwe,
  input  wire logic                  addr_ena,
  input  wire logic                  aclr,
  input  wire logic [ram_pkg::AW-1:0]  addr,
  input  wire logic [ram_pkg::BEW-1:0] be,
  input  wire logic [ram_pkg::DW-1:0]  din,
  output ram_pkg::req_t              req,
  output logic                       req_v
);
  import ram_pkg::*;

  req_t req_ff;
  logic v_ff;
  wire  clr_n = presetn & ~aclr;
  wire  take  = tick & clocken;

  // ==========================================================================
  // capture stage; clear is asynchronous so it can stop a pending access
  // all inputs registered
  always_ff @(posedge pclk or negedge clr_n) begin
    if (!clr_n) begin
      req_ff <= '0;
      v_ff   <= 1'b0;
    end else begin
      v_ff <= take;
      if (take) begin
        req_ff.wr   <= renwe;
        req_ff.be   <= be;
        req_ff.data <= din;
        // address only moves while its latch enable is high
        if (addr_ena) begin
          req_ff.addr <= addr;
        end
      end
    end
  end

  assign req   = req_ff;
  assign req_v = v_ff;

  // ==========================================================================
  // checks
  a_clr_regs_empty: assert property (
    @(posedge pclk) disable iff (!presetn) aclr |-> (!req_v && req == '0))
    else $error("input registers not cleared by port clear");

  a_capture_on_tick: assert property (
    @(posedge pclk) disable iff (!presetn) req_v |-> $past(tick && clocken))
    else $error("request appeared without a qualified port edge");

  a_addr_latch_gate: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!aclr && !$past(aclr) && $changed(req.addr)) |-> $past(take && addr_ena))
    else $error("address register moved without latch enable");
endmodule // port_regs

// ### logic/fifo_ctrl.sv
// Purpose: pointer and fill logic for the fifo operating mode
// Assumes: push and pop are one-cycle requests from the port stages
// Notes:   pointers restart whenever the fifo mode is left
`timescale 1ns/1ps
module fifo_ctrl #(
  parameter int IW = ram_pkg::IDXW
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          enable,
  input  wire logic          push,
  input  wire logic          pop,
  output logic               push_ok,
  output logic               pop_ok,
  output logic [IW-1:0]      wr_idx,
  output logic [IW-1:0]      rd_idx,
  output logic [IW:0]        count,
  output logic               full,
  output logic               empty
);
  import ram_pkg::*;

  logic [IW-1:0] wp_ff;
  logic [IW-1:0] rp_ff;
  logic [IW:0]   cnt_ff;

  // ==========================================================================
  // flags; a refused push or pop leaves the pointers alone
  assign full    = cnt_ff[IW];
  assign empty   = (cnt_ff == '0);
  assign push_ok = push & ~full;
  assign pop_ok  = pop & ~empty;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else if (!enable) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wp_ff  <= wp_ff + IW'(push_ok);
      rp_ff  <= rp_ff + IW'(pop_ok);
      cnt_ff <= cnt_ff + (IW+1)'(push_ok) - (IW+1)'(pop_ok);
    end
  end

  assign wr_idx = wp_ff;
  assign rd_idx = rp_ff;
  assign count  = cnt_ff;

  // ==========================================================================
  // checks
  a_fifo_full_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    (enable && full && push && !pop) |=> $stable(cnt_ff) && $stable(wp_ff))
    else $error("push accepted while fifo full");
endmodule // fifo_ctrl

// ### logic/big_ram.sv
// Purpose: large synchronous dual-port ram block with apb configuration
// Assumes: port clock pins are levels synchronous to pclk
// Notes:   contents are never reset and read undefined until written
`timescale 1ns/1ps
module big_ram (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [ram_pkg::PAW-1:0]  paddr,
  input  wire logic [31:0]              pwdata,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     port_clk_a,
  input  wire logic                     clk_en_a,
  input  wire logic                     wr_sel_a,
  input  wire logic                     clear_a,
  input  wire logic                     addr_latch_a,
  input  wire logic [ram_pkg::AW-1:0]   addr_a,
  input  wire logic [ram_pkg::BEW-1:0]  lane_en_a,
  input  wire logic [ram_pkg::DW-1:0]   wdata_a,
  output logic [ram_pkg::DW-1:0]        rdata_a,
  input  wire logic                     port_clk_b,
  input  wire logic                     clk_en_b,
  input  wire logic                     wr_sel_b,
  input  wire logic                     clear_b,
  input  wire logic                     addr_latch_b,
  input  wire logic [ram_pkg::AW-1:0]   addr_b,
  input  wire logic [ram_pkg::BEW-1:0]  lane_en_b,
  input  wire logic [ram_pkg::DW-1:0]   wdata_b,
  output logic [ram_pkg::DW-1:0]        rdata_b
);
  import ram_pkg::*;

  // ==========================================================================
  // configuration and status registers
  logic [7:0]    ctrl_ff;
  logic [2:0]    err_ff;
  logic [2:0]    nxt_err_ff;
  logic [31:0]   prdata_ff;
  logic          pready_ff;
  logic          pslverr_ff;

  // port clock edge detection
  logic          clk_a_ff;
  logic          clk_b_ff;

  // read pipeline
  logic [DW-1:0] stage_a_ff;
  logic [DW-1:0] stage_b_ff;
  logic [DW-1:0] dout_a_ff;
  logic [DW-1:0] dout_b_ff;

  logic [DW-1:0] mem [DEPTH];

  // ==========================================================================
  // configuration fields
  mode_t mode;
  assign mode = mode_t'(ctrl_ff[CF_MODE +: 2]);

  wire oreg_a = ctrl_ff[CF_OREG_A];
  wire isel_a = ctrl_ff[CF_ISEL_A];
  wire osel_a = ctrl_ff[CF_OSEL_A];
  wire oreg_b = ctrl_ff[CF_OREG_B];
  wire isel_b = ctrl_ff[CF_ISEL_B];
  wire osel_b = ctrl_ff[CF_OSEL_B];

  wire tdp    = (mode == MODE_TDP);
  wire sdp    = (mode == MODE_SDP);
  wire sp     = (mode == MODE_SP);
  wire fifo_m = (mode == MODE_FIFO);

  // ==========================================================================
  // port clocks; a rising level on the pin is one active edge
  // independent port clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_a_ff <= 1'b0;
      clk_b_ff <= 1'b0;
    end else begin
      clk_a_ff <= port_clk_a;
      clk_b_ff <= port_clk_b;
    end
  end

  wire tick_a = port_clk_a & ~clk_a_ff;
  wire tick_b = port_clk_b & ~clk_b_ff;

  wire in_tick_a  = isel_a ? tick_b : tick_a;
  wire out_tick_a = osel_a ? tick_b : tick_a;
  wire in_tick_b  = isel_b ? tick_a : tick_b;
  wire out_tick_b = osel_b ? tick_a : tick_b;

  // ==========================================================================
  // input register groups, one per port
  // full-width port buses
  req_t req_a;
  req_t req_b;
  logic va;
  logic vb;

  port_regs u_in_a (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick     (in_tick_a),
    .clocken  (clk_en_a),
    .renwe    (wr_sel_a),
    .addr_ena (addr_latch_a),
    .aclr     (clear_a),
    .addr     (addr_a),
    .be       (lane_en_a),
    .din      (wdata_a),
    .req      (req_a),
    .req_v    (va)
  );

  port_regs u_in_b (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick     (in_tick_b),
    .clocken  (clk_en_b),
    .renwe    (wr_sel_b),
    .addr_ena (addr_latch_b),
    .aclr     (clear_b),
    .addr     (addr_b),
    .be       (lane_en_b),
    .din      (wdata_b),
    .req      (req_b),
    .req_v    (vb)
  );

  // ==========================================================================
  // mode steering: simple dual writes on a and reads on b,
  // single port uses a only, fifo pushes on a and pops on b
  // mode access gating
  wire wr_a_go = va & req_a.wr & ~fifo_m;
  wire rd_a_go = va & ~req_a.wr & (tdp | sp);
  wire wr_b_go = vb & req_b.wr & tdp;
  wire rd_b_go = vb & ~req_b.wr & (tdp | sdp);
  wire push    = va & req_a.wr & fifo_m;
  wire pop     = vb & ~req_b.wr & fifo_m;

  logic            push_ok;
  logic            pop_ok;
  logic [IDXW-1:0] wr_idx;
  logic [IDXW-1:0] rd_idx;
  logic [CW-1:0]   fifo_cnt;
  logic            fifo_full;
  logic            fifo_empty;

  fifo_ctrl #(
    .IW (IDXW)
  ) u_fifo (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (fifo_m),
    .push    (push),
    .pop     (pop),
    .push_ok (push_ok),
    .pop_ok  (pop_ok),
    .wr_idx  (wr_idx),
    .rd_idx  (rd_idx),
    .count   (fifo_cnt),
    .full    (fifo_full),
    .empty   (fifo_empty)
  );

  // word index; high address bits beyond the array are ignored
  wire [IDXW-1:0] idx_a = fifo_m ? wr_idx : req_a.addr[IDXW-1:0];
  wire [IDXW-1:0] idx_b = fifo_m ? rd_idx : req_b.addr[IDXW-1:0];
  wire [DW-1:0]   rdw_a = mem[idx_a];
  wire [DW-1:0]   rdw_b = mem[idx_b];
  wire            wr_a  = wr_a_go | push_ok;
  wire            rd_b  = rd_b_go | pop_ok;

  // ==========================================================================
  // array writes; on a same-word collision port b lands last
  // byte lane merge
  always_ff @(posedge pclk) begin
    if (wr_a) begin
      mem[idx_a] <= merge_lanes(rdw_a, req_a.data, req_a.be);
    end
    if (wr_b_go) begin
      mem[idx_b] <= merge_lanes(rdw_b, req_b.data, req_b.be);
    end
  end

  // ==========================================================================
  // read pipeline; the internal stage feeds the optional output register
  always_ff @(posedge pclk) begin
    if (rd_a_go) begin
      stage_a_ff <= rdw_a;
    end
    if (rd_b) begin
      stage_b_ff <= rdw_b;
    end
  end

  // clear reaches the output only when that register is in use; the
  // async term mixes a config bit, so change config only while idle
  wire oclr_a_n = presetn & ~(clear_a & oreg_a);
  wire oclr_b_n = presetn & ~(clear_b & oreg_b);

  always_ff @(posedge pclk or negedge oclr_a_n) begin
    if (!oclr_a_n) begin
      dout_a_ff <= '0;
    end else if (!oreg_a) begin
      if (rd_a_go) dout_a_ff <= rdw_a;
    end else if (out_tick_a & clk_en_a) begin
      dout_a_ff <= stage_a_ff;
    end
  end

  always_ff @(posedge pclk or negedge oclr_b_n) begin
    if (!oclr_b_n) begin
      dout_b_ff <= '0;
    end else if (!oreg_b) begin
      if (rd_b) dout_b_ff <= rdw_b;
    end else if (out_tick_b & clk_en_b) begin
      dout_b_ff <= stage_b_ff;
    end
  end

  assign rdata_a = dout_a_ff;
  assign rdata_b = dout_b_ff;

  // ==========================================================================
  // apb slave: one wait state, write lands on the completing edge
  wire acc      = psel & penable & ~pready_ff;
  wire done     = psel & penable & pready_ff;
  wire hit_ctrl = (paddr == OFS_CTRL);
  wire hit_stat = (paddr == OFS_STAT);
  wire hit_err  = (paddr == OFS_ERR);
  wire mapped   = hit_ctrl | hit_stat | hit_err;

  wire [31:0] stat_w = {2'h0, fifo_cnt, 14'h0, fifo_full, fifo_empty};
  wire [31:0] rd_mux = hit_ctrl ? {24'h0, ctrl_ff} :
                       hit_stat ? stat_w :
                       hit_err  ? {29'h0, err_ff} : 32'h0;

  // sticky errors: set wins over a write-one-to-clear in the same cycle
  wire [2:0] err_set;
  assign err_set[EF_OVF] = push & fifo_full;
  assign err_set[EF_UDF] = pop & fifo_empty;
  assign err_set[EF_REF] = (va & ~(wr_a_go | rd_a_go | push)) |
                           (vb & ~(wr_b_go | rd_b_go | pop));
  wire [2:0] err_clr = (done & pwrite & hit_err) ? pwdata[2:0] : 3'h0;
  assign nxt_err_ff = (err_ff & ~err_clr) | err_set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff    <= CTRL_RST;
      err_ff     <= ERR_RST;
      prdata_ff  <= 32'h0;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      err_ff     <= nxt_err_ff;
      pready_ff  <= acc;
      pslverr_ff <= acc & ~mapped;
      if (acc) prdata_ff <= pwrite ? 32'h0 : rd_mux;
      if (done & pwrite & hit_ctrl) ctrl_ff <= pwdata[7:0];
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

  // ==========================================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [IDXW-1:0] chk_idx_ff;
  logic [DW-1:0]   chk_word_ff;
  // expected word after a lone port a write
  always_ff @(posedge pclk) begin
    chk_idx_ff  <= idx_a;
    chk_word_ff <= merge_lanes(rdw_a, req_a.data, req_a.be);
  end
  sequence s_byp_read_a;
    rd_a_go && !oreg_a && !clear_a;
  endsequence
  // port edges are at least two cycles apart, so the output edge comes later
  sequence s_reg_read_a;
    rd_a_go && oreg_a && !clear_a && !(out_tick_a && clk_en_a)
      ##1 !(out_tick_a && clk_en_a) && !rd_a_go && !clear_a
      ##1 out_tick_a && clk_en_a && !clear_a && !rd_a_go;
  endsequence
  a_byte_lane_merge: assert property (
    (wr_a && !wr_b_go) |=> mem[chk_idx_ff] == chk_word_ff)
    else $error("write altered a disabled byte lane");
  a_out_clear_now: assert property (
    (clear_a && oreg_a) |-> rdata_a == '0)
    else $error("output register not cleared at once");
  a_bypass_one_step: assert property (
    s_byp_read_a |=> rdata_a == $past(rdw_a))
    else $error("bypassed read data not on output next cycle");
  a_out_reg_delay: assert property (
    s_reg_read_a |=> rdata_a == $past(rdw_a, 3))
    else $error("registered read data wrong after output edge");
  a_mode_b_writes: assert property (
    (vb && req_b.wr && !tdp && !wr_a) |=> mem[$past(idx_b)] == $past(rdw_b))
    else $error("port b wrote outside true dual-port mode");
  a_single_port_idle: assert property (
    (sp && vb && !oreg_b && !clear_b) |=> $stable(rdata_b))
    else $error("port b active in single-port mode");
  a_refused_sticky: assert property (
    (vb && sp) |=> err_ff[EF_REF] [*2])
    else $error("refused access not recorded");
  a_apb_one_wait: assert property (
    (psel && penable && !pready) |=> pready ##1 !pready)
    else $error("apb answer not one cycle after access");
endmodule // big_ram

// ### verification/port_user.sv
// Purpose: user logic that drives one port of the ram block
// Assumes: every signal changes right after a rising pclk edge
// Notes:   released address, lanes and data show inverted values
`timescale 1ns/1ps
module port_user (
  input  wire logic                    pclk,
  output logic                         port_clk,
  output logic                         clk_en,
  output logic                         wr_sel,
  output logic                         clear,
  output logic                         addr_latch,
  output logic [ram_pkg::AW-1:0]       addr,
  output logic [ram_pkg::BEW-1:0]      lane_en,
  output logic [ram_pkg::DW-1:0]       wdata,
  input  wire logic [ram_pkg::DW-1:0]  rdata
);
  import ram_pkg::*;

  // ==========================================================================
  // idle levels at time zero
  initial begin
    port_clk   = 1'b0;
    clk_en     = 1'b0;
    wr_sel     = 1'b0;
    clear      = 1'b0;
    addr_latch = 1'b0;
    addr       = '0;
    lane_en    = '0;
    wdata      = '0;
  end

  // ==========================================================================
  // one access; drop raises the clear right after capture
  // control group together
  task automatic access(input logic w, input logic [AW-1:0] a, input logic [BEW-1:0] be,
                        input logic [DW-1:0] d, input logic drop, output logic [DW-1:0] q);
    @(posedge pclk);
    port_clk   <= 1'b1;
    clk_en     <= 1'b1;
    wr_sel     <= w;
    addr_latch <= 1'b1;
    addr       <= a;
    lane_en    <= be;
    wdata      <= d;
    @(posedge pclk);
    // port clock must fall so the next edge is distinct
    port_clk   <= 1'b0;
    clk_en     <= 1'b0;
    addr_latch <= 1'b0;
    addr       <= ~a;
    lane_en    <= ~be;
    wdata      <= ~d;
    clear      <= drop;
    @(posedge pclk);
    clear      <= 1'b0;
    #1 q = rdata;
  endtask

  // level change of the clear alone
  task automatic hold_clear(input logic v);
    @(posedge pclk);
    clear <= v;
  endtask
endmodule // port_user

// ### verification/testbench.sv
// Purpose: self-checking bench of the large dual-port ram block
// Assumes: 100 MHz pclk, one wait state on apb
// Notes:   only written words are read back, unwritten ones are undefined
`timescale 1ns/1ps
module testbench;
  import ram_pkg::*;
  logic                pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [PAW-1:0]      paddr;
  logic [31:0]         pwdata, prdata, rd;
  logic                ka, ea, wa, ca, la, kb, eb, wb, cb, lb, er;
  logic [AW-1:0]       aa, ab;
  logic [BEW-1:0]      ba, bb;
  logic [DW-1:0]       da, db, ra, rb, q, w;
  logic [DW-1:0]       mem [int];
  logic [AW-1:0]       adr [4];
  int                  miscompares, tests_run, seed;

  big_ram big_ram_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_clk_a(ka), .clk_en_a(ea), .wr_sel_a(wa), .clear_a(ca),
    .addr_latch_a(la), .addr_a(aa), .lane_en_a(ba), .wdata_a(da), .rdata_a(ra),
    .port_clk_b(kb), .clk_en_b(eb), .wr_sel_b(wb), .clear_b(cb), .addr_latch_b(lb),
    .addr_b(ab), .lane_en_b(bb), .wdata_b(db), .rdata_b(rb));
  port_user pa (.pclk(pclk), .port_clk(ka), .clk_en(ea), .wr_sel(wa), .clear(ca),
    .addr_latch(la), .addr(aa), .lane_en(ba), .wdata(da), .rdata(ra));
  port_user pb (.pclk(pclk), .port_clk(kb), .clk_en(eb), .wr_sel(wb), .clear(cb),
    .addr_latch(lb), .addr(ab), .lane_en(bb), .wdata(db), .rdata(rb));

  // ==========================================================================
  // clock, and a watchdog so no hang outlives the cycle budget
  initial pclk = 1'b0;
  always #5 pclk = ~pclk;
  initial begin
    repeat (100000) @(posedge pclk);
    miscompares++;
    $display("MISMATCH t=%0t watchdog", $time);
    final_report();
  end

  // ==========================================================================
  // reference helpers
  function automatic logic [DW-1:0] lanes(input logic [DW-1:0] o, input logic [DW-1:0] n,
                                          input logic [BEW-1:0] be);
    for (int i = 0; i < BEW; i++) if (be[i]) o[i*LANE +: LANE] = n[i*LANE +: LANE];
    return o;
  endfunction
  function automatic logic [DW-1:0] rnd72();
    logic [95:0] t;
    t = {$urandom, $urandom, $urandom};
    return t[DW-1:0];
  endfunction
  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // apb transfer; read data and error land in rd and er
  task automatic apb(input logic wr, input logic [PAW-1:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    rd = prdata;
    er = pslverr;
    if (n >= 20) begin
      chk(0, 1, "apb timeout");
      final_report();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    logic [BEW-1:0] be;
    logic           b, wr;
    int             k;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    seed = $urandom(67081);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // register reset values and a refused address
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 32'h0, "ctrl reset");
    apb(1'b0, OFS_STAT, 32'h0);
    chk(rd, 32'h1, "stat reset");
    apb(1'b0, OFS_ERR, 32'h0);
    chk(rd, 32'h0, "err reset");
    apb(1'b0, 8'h0C, 32'h0);
    chk({er, rd}, 33'h100000000, "unmapped read");
    apb(1'b1, OFS_CTRL, 32'h000000A5);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 32'h000000A5, "ctrl readback");
    apb(1'b1, OFS_CTRL, 32'h0);
    $display("test registers done");
    // true dual-port traffic with random lanes, edge addresses included
    adr = '{16'h0000, 16'(DEPTH - 1), 16'($urandom_range(DEPTH - 2, 1)), 16'h0AAA};
    for (int i = 0; i < 4; i++) begin
      w = rnd72();
      pa.access(1'b1, adr[i], 8'hFF, w, 1'b0, q);
      mem[adr[i]] = w;
    end
    for (int i = 0; i < 40; i++) begin
      k = $urandom_range(3);
      be = 8'($urandom);
      w = rnd72();
      b = 1'($urandom);
      wr = 1'($urandom);
      if (b) pb.access(wr, adr[k], be, w, 1'b0, q);
      else pa.access(wr, adr[k], be, w, 1'b0, q);
      if (wr) mem[adr[k]] = lanes(mem[adr[k]], w, be);
      else chk(q, mem[adr[k]], "dual-port read");
    end
    $display("test dual port done");
    // a clear right after capture drops the pending write
    pa.access(1'b1, adr[0], 8'hFF, ~mem[adr[0]], 1'b1, q);
    pb.access(1'b0, adr[0], 8'h00, '0, 1'b0, q);
    chk(q, mem[adr[0]], "write after clear");
    $display("test input clear done");
    // output register on port a, then its immediate clear
    apb(1'b1, OFS_CTRL, 32'h4);
    pa.access(1'b0, adr[1], 8'h00, '0, 1'b0, q);
    pa.access(1'b0, adr[1], 8'h00, '0, 1'b0, q);
    repeat (2) @(posedge pclk);
    chk(ra, mem[adr[1]], "registered read");
    pa.hold_clear(1'b1);
    #1 chk(ra, '0, "output clear");
    pa.hold_clear(1'b0);
    $display("test output register done");
    // port a input stage on port b clock: its own edge captures nothing
    apb(1'b1, OFS_CTRL, 32'h8);
    pa.access(1'b1, adr[3], 8'hFF, ~mem[adr[3]], 1'b0, q);
    pb.access(1'b0, adr[3], 8'h00, '0, 1'b0, q);
    chk(q, mem[adr[3]], "input clock select");
    $display("test clock select done");
    // simple dual-port: b may not write
    apb(1'b1, OFS_CTRL, {30'h0, MODE_SDP});
    pb.access(1'b1, adr[2], 8'hFF, ~mem[adr[2]], 1'b0, q);
    apb(1'b0, OFS_ERR, 32'h0);
    chk(rd, 32'h4, "refused write flag");
    apb(1'b1, OFS_ERR, 32'h4);
    apb(1'b0, OFS_ERR, 32'h0);
    chk(rd, 32'h0, "flag cleared");
    pb.access(1'b0, adr[2], 8'h00, '0, 1'b0, q);
    chk(q, mem[adr[2]], "sdp read");
    // single-port: port a writes and reads
    apb(1'b1, OFS_CTRL, {30'h0, MODE_SP});
    w = rnd72();
    pa.access(1'b1, adr[3], 8'h0F, w, 1'b0, q);
    mem[adr[3]] = lanes(mem[adr[3]], w, 8'h0F);
    pb.access(1'b1, adr[3], 8'hFF, ~w, 1'b0, q);
    pa.access(1'b0, adr[3], 8'h00, '0, 1'b0, q);
    chk(q, mem[adr[3]], "single-port read");
    apb(1'b0, OFS_ERR, 32'h0);
    chk(rd, 32'h4, "single-port refusal flag");
    apb(1'b1, OFS_ERR, 32'h4);
    $display("test modes done");
    // fifo: pushes on a, pops on b, in order, then an empty pop
    apb(1'b1, OFS_CTRL, {30'h0, MODE_FIFO});
    for (int i = 0; i < 3; i++) begin
      pa.access(1'b1, adr[i], 8'hFF, mem[adr[i]], 1'b0, q);
    end
    apb(1'b0, OFS_STAT, 32'h0);
    chk(rd, 32'h00030000, "fifo count");
    for (int i = 0; i < 3; i++) begin
      pb.access(1'b0, adr[3], 8'h00, '0, 1'b0, q);
      chk(q, mem[adr[i]], "fifo order");
    end
    pb.access(1'b0, adr[3], 8'h00, '0, 1'b0, q);
    apb(1'b0, OFS_ERR, 32'h0);
    chk(rd, 32'h2, "empty pop flag");
    // fill the whole array, then one push past full is dropped and flagged
    for (int i = 0; i <= DEPTH; i++) begin
      pa.access(1'b1, 16'(i), 8'hFF, rnd72(), 1'b0, q);
    end
    apb(1'b0, OFS_STAT, 32'h0);
    chk(rd, (32'(DEPTH) << 16) | 32'h2, "fifo full");
    apb(1'b0, OFS_ERR, 32'h0);
    chk(rd, 32'h3, "full push flag");
    $display("test fifo done");
    final_report();
  end
endmodule // testbench
